// File: verilog/wfm_timer_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef WFM_TIMER_MAP_SVH
`define WFM_TIMER_MAP_SVH

`define OFF_PRIMARY 8'h00
`define OFF_WAVE 8'h04
`define OFF_OUTCTL 8'h08
`define OFF_STROBE 8'h0c
`define OFF_STATUS 8'h10
`define OFF_CMP_A_SET 8'h14
`define OFF_CMP_A_CLR 8'h18
`define OFF_CMP_B_SET 8'h1c
`define OFF_CMP_B_CLR 8'h20
`define OFF_FAULT 8'h24
`define OFF_UNLOCK 8'h28
`define OFF_COUNT 8'h2c

`define EN_BIT 0
`define PRESC_LSB 1
`define MODE_LSB 0
`define AUPD_BIT 0
`define STB_SYNC 0
`define STB_EOC 1
`define FLT_OVR 0
`define FLT_BLANK 1
`define FLT_TRIG 2
`define FLT_LEN_LSB 4

`define RST_HREADY 1'b1
`define RST_UNLOCK_KEY 32'h0000_00a5
`define RST_UNLOCK_WINDOW 3'h4
`define HSIZE_WORD 3'h2
`define SYNC_CYCLES 2'h2

`endif

// File: verilog/wfm_timer_pkg.sv
// Types shared by the waveform timer and its prescaler
package wfm_timer_pkg;

    typedef enum logic [1:0] {
        one_ramp, two_ramp, four_ramp, dual_slope
    } mode_t;

    typedef enum logic [1:0] {
        dead_time_a_state, on_time_a_state,
        dead_time_b_state, on_time_b_state
    } phase_t;

    typedef struct packed {
        logic [11:0] compare_a_set_value;
        logic [11:0] compare_a_clear_value;
        logic [11:0] compare_b_set_value;
        logic [11:0] compare_b_clear_value;
    } cmp_set_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } ahb_rsp_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } presc_state_t;

    typedef struct packed {
        logic busy;
        logic wr;
        logic [7:0] addr;
        ahb_rsp_t rsp;
        logic enable;
        logic [1:0] presc;
        mode_t mode;
        logic auto_update_bit;
        logic [15:0] fault_ctl;
        logic [2:0] unlock;
        cmp_set_t staged;
        cmp_set_t act;
        logic [1:0] en_cnt;
        logic [1:0] cmd_cnt;
        logic [1:0] strobe;
        logic core_en;
        logic [11:0] cnt;
        logic up;
        phase_t phase;
        logic eoc_pend;
        logic out_a;
        logic out_b;
        logic fault;
        logic [11:0] blank;
        logic wo_a;
        logic wo_b;
    } timer_state_t;

endpackage

// File: verilog/count_prescaler.sv
// Counter clock prescaler: one-cycle tick every 1, 2, 4 or 8 clocks
`timescale 1ns/1ps
`include "wfm_timer_map.svh"
module count_prescaler (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [1:0] div_sel,
    output logic tick
);
    import wfm_timer_pkg::*;

    presc_state_t st;
    presc_state_t next_st;
    logic [2:0] top;

    assign top = 3'((4'h1 << div_sel) - 4'h1);
    assign tick = st.tick;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!run) begin
            next_st.cnt = 3'h0;
        end else if (st.cnt >= top) begin
            next_st.cnt = 3'h0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 3'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    tick_stop_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !run |=> !tick) else $error("tick while stopped");
endmodule

// File: verilog/ramp_waveform_timer_sync.sv
// Waveform timer: AHB-Lite registers, sync stage and ramp counter core
`timescale 1ns/1ps
`include "wfm_timer_map.svh"
module ramp_waveform_timer_sync #(
    // Arbitrary key value
    parameter logic [31:0] UNLOCK_KEY = `RST_UNLOCK_KEY,
    parameter logic [2:0] UNLOCK_WINDOW = `RST_UNLOCK_WINDOW
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wfm_timer_pkg::ahb_req_t bus_req,
    input wire logic event_in,
    output wfm_timer_pkg::ahb_rsp_t bus_rsp,
    output logic waveform_output_a,
    output logic waveform_output_b
);
    import wfm_timer_pkg::*;

    timer_state_t st;
    timer_state_t next_st;
    logic tick;
    logic take;
    logic exec;
    logic eoc;
    logic ev;
    logic [31:0] d;

    function automatic logic en_ready(input timer_state_t s);
        return s.en_cnt == 2'h0;
    endfunction

    function automatic logic cmd_ready(input timer_state_t s);
        return s.en_cnt == 2'h0 && s.cmd_cnt == 2'h0;
    endfunction

    function automatic logic staged_ok(input timer_state_t s);
        return !s.enable || cmd_ready(s);
    endfunction

    function automatic logic [11:0] ramp_top(input cmp_set_t c,
                                             input phase_t p);
        unique case (p)
            dead_time_a_state: return c.compare_a_set_value;
            on_time_a_state: return c.compare_a_clear_value;
            dead_time_b_state: return c.compare_b_set_value;
            on_time_b_state: return c.compare_b_clear_value;
        endcase
    endfunction

    count_prescaler u_presc (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .run(st.core_en),
        .div_sel(st.presc),
        .tick(tick)
    );

    assign take = bus_req.hsel && bus_req.htrans[1] && bus_req.hready;
    assign exec = st.busy;
    assign d = bus_req.hwdata;
    assign bus_rsp = st.rsp;
    assign waveform_output_a = st.wo_a;
    assign waveform_output_b = st.wo_b;

    always_comb begin
        next_st = st;
        eoc = 1'b0;
        // Blanking is counted in counter ticks, events sampled every clock
        ev = event_in && !(st.fault_ctl[`FLT_BLANK] && st.blank != 12'h0);
        if (st.unlock != 3'h0) begin
            next_st.unlock = st.unlock - 3'h1;
        end
        if (tick && st.blank != 12'h0) begin
            next_st.blank = st.blank - 12'h001;
        end

        // Counter core, advanced once per prescaled tick
        if (tick && st.core_en) begin
            unique case (st.mode)
                one_ramp: begin
                    next_st.cnt = st.cnt + 12'h001;
                    if (st.cnt == st.act.compare_a_set_value) begin
                        next_st.out_a = 1'b1;
                        next_st.phase = on_time_a_state;
                    end
                    if (st.cnt == st.act.compare_a_clear_value) begin
                        next_st.out_a = 1'b0;
                        next_st.phase = dead_time_b_state;
                    end
                    if (st.cnt == st.act.compare_b_set_value) begin
                        next_st.out_b = 1'b1;
                        next_st.phase = on_time_b_state;
                    end
                    if (st.cnt == st.act.compare_b_clear_value) begin
                        eoc = 1'b1;
                    end
                end
                two_ramp: begin
                    next_st.cnt = st.cnt + 12'h001;
                    if (st.phase == dead_time_a_state ||
                        st.phase == on_time_a_state) begin
                        if (st.cnt == st.act.compare_a_set_value) begin
                            next_st.out_a = 1'b1;
                            next_st.phase = on_time_a_state;
                        end
                        if (st.cnt == st.act.compare_a_clear_value) begin
                            next_st.out_a = 1'b0;
                            next_st.cnt = 12'h000;
                            next_st.phase = dead_time_b_state;
                        end
                    end else begin
                        if (st.cnt == st.act.compare_b_set_value) begin
                            next_st.out_b = 1'b1;
                            next_st.phase = on_time_b_state;
                        end
                        if (st.cnt == st.act.compare_b_clear_value) begin
                            eoc = 1'b1;
                        end
                    end
                end
                four_ramp: begin
                    next_st.cnt = st.cnt + 12'h001;
                    if (st.cnt == ramp_top(st.act, st.phase)) begin
                        next_st.cnt = 12'h000;
                        unique case (st.phase)
                            dead_time_a_state: begin
                                next_st.out_a = 1'b1;
                                next_st.phase = on_time_a_state;
                            end
                            on_time_a_state: begin
                                next_st.out_a = 1'b0;
                                next_st.phase = dead_time_b_state;
                            end
                            dead_time_b_state: begin
                                next_st.out_b = 1'b1;
                                next_st.phase = on_time_b_state;
                            end
                            on_time_b_state: begin
                                eoc = 1'b1;
                            end
                        endcase
                    end
                end
                dual_slope: begin
                    if (st.up) begin
                        if (st.cnt == st.act.compare_a_set_value) begin
                            next_st.out_a = 1'b0;
                        end
                        if (st.cnt == st.act.compare_b_set_value) begin
                            next_st.out_b = 1'b1;
                        end
                        if (st.cnt == st.act.compare_b_clear_value) begin
                            eoc = 1'b1;
                            next_st.up = 1'b0;
                        end else begin
                            next_st.cnt = st.cnt + 12'h001;
                        end
                    end else begin
                        if (st.cnt == st.act.compare_a_set_value) begin
                            next_st.out_a = 1'b1;
                        end
                        if (st.cnt == st.act.compare_b_set_value) begin
                            next_st.out_b = 1'b0;
                        end
                        if (st.cnt == 12'h000) begin
                            next_st.up = 1'b1;
                        end else begin
                            next_st.cnt = st.cnt - 12'h001;
                        end
                    end
                end
            endcase
            if (eoc) begin
                next_st.out_a = 1'b0;
                next_st.out_b = 1'b0;
                next_st.phase = dead_time_a_state;
                if (st.eoc_pend) begin
                    next_st.act = st.staged;
                    next_st.eoc_pend = 1'b0;
                end
                next_st.cnt = (st.mode == dual_slope) ?
                    next_st.act.compare_b_clear_value : 12'h000;
            end
            if (st.fault_ctl[`FLT_TRIG] ?
                (next_st.phase == on_time_b_state &&
                 st.phase != on_time_b_state) : eoc) begin
                next_st.blank = st.fault_ctl[`FLT_LEN_LSB +: 12];
            end
        end

        // Fault latch holds until the timer is disabled
        if (st.core_en && st.fault_ctl[`FLT_OVR] && ev) begin
            next_st.fault = 1'b1;
        end

        // Bus: every transfer takes one wait state
        if (exec) begin
            next_st.busy = 1'b0;
            next_st.rsp.hreadyout = 1'b1;
            if (!st.wr) begin
                case (st.addr)
                    `OFF_PRIMARY: next_st.rsp.hrdata =
                        {29'h0, st.presc, st.enable};
                    `OFF_WAVE: next_st.rsp.hrdata = {30'h0, st.mode};
                    `OFF_OUTCTL: next_st.rsp.hrdata = {31'h0, st.auto_update_bit};
                    `OFF_STROBE: next_st.rsp.hrdata = {30'h0, st.strobe};
                    `OFF_STATUS: next_st.rsp.hrdata = {27'h0, st.wo_b,
                        st.wo_a, st.core_en, cmd_ready(st), en_ready(st)};
                    `OFF_CMP_A_SET: next_st.rsp.hrdata =
                        {20'h0, st.staged.compare_a_set_value};
                    `OFF_CMP_A_CLR: next_st.rsp.hrdata =
                        {20'h0, st.staged.compare_a_clear_value};
                    `OFF_CMP_B_SET: next_st.rsp.hrdata =
                        {20'h0, st.staged.compare_b_set_value};
                    `OFF_CMP_B_CLR: next_st.rsp.hrdata =
                        {20'h0, st.staged.compare_b_clear_value};
                    `OFF_FAULT: next_st.rsp.hrdata = {16'h0, st.fault_ctl};
                    `OFF_COUNT: next_st.rsp.hrdata = {20'h0, st.cnt};
                    default: next_st.rsp.hrdata = 32'h0;
                endcase
            end else begin
                case (st.addr)
                    `OFF_PRIMARY: begin
                        if (en_ready(st) && d[`EN_BIT] != st.enable) begin
                            next_st.enable = d[`EN_BIT];
                            next_st.en_cnt = `SYNC_CYCLES;
                        end
                        if (!st.enable) begin
                            next_st.presc = d[`PRESC_LSB +: 2];
                        end
                    end
                    `OFF_WAVE: if (!st.enable) begin
                        next_st.mode = mode_t'(d[`MODE_LSB +: 2]);
                    end
                    `OFF_OUTCTL: if (!st.enable) begin
                        next_st.auto_update_bit = d[`AUPD_BIT];
                    end
                    `OFF_STROBE: begin
                        if (st.core_en && cmd_ready(st) &&
                            d[1:0] != 2'h0) begin
                            next_st.strobe = d[1:0];
                            next_st.cmd_cnt = `SYNC_CYCLES;
                        end
                    end
                    `OFF_CMP_A_SET: if (staged_ok(st)) begin
                        next_st.staged.compare_a_set_value = d[11:0];
                    end
                    `OFF_CMP_A_CLR: if (staged_ok(st)) begin
                        next_st.staged.compare_a_clear_value = d[11:0];
                    end
                    `OFF_CMP_B_SET: if (staged_ok(st)) begin
                        next_st.staged.compare_b_set_value = d[11:0];
                    end
                    `OFF_CMP_B_CLR: if (staged_ok(st)) begin
                        next_st.staged.compare_b_clear_value = d[11:0];
                        if (st.auto_update_bit && st.core_en) begin
                            next_st.eoc_pend = 1'b1;
                        end
                    end
                    `OFF_FAULT: begin
                        if (st.unlock != 3'h0 && !st.enable) begin
                            next_st.fault_ctl = d[15:0];
                            next_st.unlock = 3'h0;
                        end
                    end
                    `OFF_UNLOCK: if (d == UNLOCK_KEY) begin
                        next_st.unlock = UNLOCK_WINDOW;
                    end
                    default: ;
                endcase
            end
        end else if (take) begin
            next_st.busy = 1'b1;
            next_st.rsp.hreadyout = 1'b0;
            next_st.addr = bus_req.haddr[7:0];
            next_st.wr = bus_req.hwrite && bus_req.hsize == `HSIZE_WORD;
        end

        // Command crossing completes; strobe empties when delivered
        if (st.cmd_cnt != 2'h0) begin
            next_st.cmd_cnt = st.cmd_cnt - 2'h1;
        end
        if (st.cmd_cnt == 2'h1) begin
            next_st.strobe = 2'h0;
            if (st.strobe[`STB_SYNC]) begin
                next_st.act = st.staged;
            end
            if (st.strobe[`STB_EOC]) begin
                next_st.eoc_pend = 1'b1;
            end
        end

        // Enable crossing completes last so it overrides the core
        if (st.en_cnt != 2'h0) begin
            next_st.en_cnt = st.en_cnt - 2'h1;
        end
        if (st.en_cnt == 2'h1) begin
            next_st.core_en = st.enable;
            next_st.out_a = 1'b0;
            next_st.out_b = 1'b0;
            next_st.eoc_pend = 1'b0;
            next_st.phase = dead_time_a_state;
            next_st.fault = 1'b0;
            next_st.blank = 12'h000;
            if (st.enable) begin
                next_st.act = st.staged;
                next_st.up = st.mode != dual_slope;
                next_st.cnt = (st.mode == dual_slope) ?
                    st.staged.compare_b_clear_value : 12'h000;
            end
        end
        next_st.wo_a = next_st.out_a && !next_st.fault;
        next_st.wo_b = next_st.out_b && !next_st.fault;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.rsp.hreadyout <= `RST_HREADY;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    en_gate_a: assert property (
        exec && st.wr && st.addr == `OFF_PRIMARY && st.en_cnt != 2'h0
        |=> st.enable == $past(st.enable)) else $error("enable not gated");
    protect_a: assert property (
        exec && st.wr && st.addr == `OFF_PRIMARY && st.enable
        |=> st.presc == $past(st.presc)) else $error("prescaler changed");
    static_mode_a: assert property (
        st.enable |=> st.mode == $past(st.mode) || !$past(st.enable))
        else $error("mode changed while enabled");
    strobe_clear_a: assert property (
        st.cmd_cnt == 2'h1 |=> st.strobe == 2'h0 ##1 st.cmd_cnt == 2'h0)
        else $error("strobe not cleared");
    cmd_ignore_a: assert property (
        exec && st.wr && st.addr == `OFF_STROBE && st.cmd_cnt > 2'h1
        |=> st.cmd_cnt == $past(st.cmd_cnt) - 2'h1)
        else $error("command taken during sync");
    bclr_clear_a: assert property (
        tick && st.core_en && st.mode == one_ramp && st.en_cnt == 2'h0 &&
        st.cnt == st.act.compare_b_clear_value
        |=> !st.out_a && !st.out_b && st.cnt == 12'h000)
        else $error("cycle end not cleared");
    ramp_step_a: assert property (
        tick && st.core_en && st.mode == one_ramp && st.en_cnt == 2'h0 &&
        st.cnt != st.act.compare_b_clear_value
        |=> st.cnt == $past(st.cnt) + 12'h001) else $error("bad step");
    aset_a: assert property (
        tick && st.core_en && st.mode == one_ramp && st.en_cnt == 2'h0 &&
        st.cnt == st.act.compare_a_set_value &&
        st.cnt != st.act.compare_a_clear_value &&
        st.cnt != st.act.compare_b_clear_value |=> st.out_a)
        else $error("output a not set");
    sync_load_a: assert property (
        st.cmd_cnt == 2'h1 && st.strobe[`STB_SYNC] && st.en_cnt == 2'h0
        && !(tick && st.core_en && st.eoc_pend)
        |=> st.act == $past(st.staged)) else $error("sync not loaded");
    unlock_a: assert property (
        exec && st.wr && st.addr == `OFF_FAULT && st.unlock == 3'h0
        |=> $stable(st.fault_ctl)) else $error("fault ctl unlocked");
    fault_out_a: assert property (
        st.fault |-> !waveform_output_a && !waveform_output_b)
        else $error("fault did not mask outputs");

    enable_c: cover property ($rose(st.core_en));
    eoc_load_c: cover property (tick && st.core_en && st.eoc_pend && eoc);
    fault_c: cover property ($rose(st.fault));
    dual_c: cover property (st.mode == dual_slope && $fell(st.up));
endmodule

// File: tb/power_stage_model.sv
// Power stage stand-in: gate pulse widths, period, overlap
`timescale 1ns/1ps
module power_stage_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic gate_a,
    input wire logic gate_b,
    output logic [15:0] width_a,
    output logic [15:0] width_b,
    output logic [15:0] period_a,
    output logic shoot_through
);
    logic [15:0] run_a, run_b, since_a;
    logic last_a, last_b;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            {width_a, width_b, period_a} <= '0;
            {run_a, run_b, since_a} <= '0;
            {last_a, last_b, shoot_through} <= '0;
        end else begin
            last_a <= gate_a;
            last_b <= gate_b;
            run_a <= gate_a ? run_a + 16'h1 : 16'h0;
            run_b <= gate_b ? run_b + 16'h1 : 16'h0;
            since_a <= (gate_a && !last_a) ? 16'h1 : since_a + 16'h1;
            if (gate_a && !last_a) period_a <= since_a;
            if (!gate_a && last_a) width_a <= run_a;
            if (!gate_b && last_b) width_b <= run_b;
            // Both legs on shorts the supply; sticky until reset
            if (gate_a && gate_b) shoot_through <= 1'b1;
        end
    end
endmodule

// File: tb/test_ramp_waveform_timer_sync.sv
// Bench for the waveform timer: bus tasks and sequenced tests
`timescale 1ns/1ps
`include "wfm_timer_map.svh"
module test_ramp_waveform_timer_sync;
    import wfm_timer_pkg::*;
    logic ref_clk;
    logic nrst;
    logic event_in;
    ahb_req_t rq;
    ahb_req_t bus_in;
    ahb_rsp_t rsp;
    logic wo_a, wo_b, shoot;
    logic [15:0] wid_a, wid_b, per_a;
    logic [31:0] q;
    int mismatches;
    int samples_checked;
    int n;

    // Single slave: its hreadyout is the bus hready
    always_comb begin
        bus_in = rq;
        bus_in.hready = rsp.hreadyout;
    end

    ramp_waveform_timer_sync u_ramp_waveform_timer_sync (
        .ref_clk(ref_clk), .nrst(nrst), .bus_req(bus_in),
        .event_in(event_in), .bus_rsp(rsp),
        .waveform_output_a(wo_a), .waveform_output_b(wo_b));
    power_stage_model u_power_stage_model (
        .ref_clk(ref_clk), .nrst(nrst), .gate_a(wo_a), .gate_b(wo_b),
        .width_a(wid_a), .width_b(wid_b), .period_a(per_a),
        .shoot_through(shoot));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        $display("checked %0d mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; waits are bounded
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int k;
        k = 0;
        rq.hsel <= 1'b1;
        rq.haddr <= {24'h0, a};
        rq.htrans <= 2'h2;
        rq.hwrite <= w;
        rq.hsize <= 3'h2;
        do begin @(posedge ref_clk); k++; end
        while (rsp.hreadyout !== 1'b1 && k < 50);
        rq.htrans <= 2'h0;
        rq.hsel <= 1'b0;
        rq.hwdata <= d;
        do begin @(posedge ref_clk); k++; end
        while (rsp.hreadyout !== 1'b1 && k < 50);
        q = rsp.hrdata;
        if (k >= 50) begin
            mismatches++;
            summarize();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
        chk({31'h0, rsp.hresp}, 32'h0);
    endtask

    // Status flag poll; a flag that never comes ends the run
    task automatic poll(input int b, input logic v);
        n = 0;
        do begin xfer(1'b0, 8'h10, 32'h0); n++; end
        while (q[b] !== v && n < 40);
        if (n >= 40) begin
            mismatches++;
            summarize();
        end
    endtask

    // Run one mode from a stopped core; two rises of A give the period
    task automatic run_mode(input logic [31:0] m, input logic [31:0] p);
        xfer(1'b1, 8'h04, m);
        poll(0, 1'b1);
        xfer(1'b1, 8'h00, 32'h1);
        poll(2, 1'b1);
        repeat (80) @(posedge ref_clk);
        chk({16'h0, per_a}, p);
        poll(0, 1'b1);
        xfer(1'b1, 8'h00, 32'h0);
        poll(2, 1'b0);
    endtask

    initial begin
        nrst = 1'b0;
        event_in = 1'b0;
        rq = '0;
        mismatches = 0;
        samples_checked = 0;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rd(8'h00, 32'h0);
        rd(8'h3c, 32'h0);
        xfer(1'b1, 8'h04, 32'h0);
        xfer(1'b1, 8'h14, 32'h2);
        xfer(1'b1, 8'h18, 32'h5);
        xfer(1'b1, 8'h1c, 32'h7);
        xfer(1'b1, 8'h20, 32'ha);
        rd(8'h20, 32'ha);
        poll(0, 1'b1);
        xfer(1'b1, 8'h00, 32'h1);
        poll(2, 1'b1);
        xfer(1'b1, 8'h04, 32'h3);
        rd(8'h04, 32'h0);
        xfer(1'b1, 8'h00, 32'h7);
        rd(8'h00, 32'h1);
        $display("test enable done");
        // Enough for three full cycles of eleven ticks
        repeat (40) @(posedge ref_clk);
        chk({16'h0, per_a}, 32'hb);
        chk({16'h0, wid_a}, 32'h3);
        chk({16'h0, wid_b}, 32'h3);
        chk({31'h0, shoot}, 32'h0);
        $display("test one ramp done");
        poll(1, 1'b1);
        xfer(1'b1, 8'h20, 32'he);
        xfer(1'b1, 8'h0c, 32'h1);
        poll(1, 1'b1);
        rd(8'h0c, 32'h0);
        repeat (60) @(posedge ref_clk);
        chk({16'h0, per_a}, 32'hf);
        chk({16'h0, wid_b}, 32'h7);
        $display("test sync done");
        poll(0, 1'b1);
        xfer(1'b1, 8'h00, 32'h0);
        poll(2, 1'b0);
        $display("test disable done");
        // Periods: 6+15 and 3+6+8+15 and 2 x 15 ticks
        run_mode(32'h1, 32'h15);
        run_mode(32'h2, 32'h20);
        run_mode(32'h3, 32'h1e);
        $display("test modes done");
        xfer(1'b1, 8'h24, 32'h1);
        rd(8'h24, 32'h0);
        xfer(1'b1, 8'h28, `RST_UNLOCK_KEY);
        xfer(1'b1, 8'h24, 32'h1);
        rd(8'h24, 32'h1);
        poll(0, 1'b1);
        xfer(1'b1, 8'h00, 32'h1);
        poll(2, 1'b1);
        event_in <= 1'b1;
        repeat (2) @(posedge ref_clk);
        n = 0;
        repeat (40) begin
            @(posedge ref_clk);
            if (wo_a !== 1'b0 || wo_b !== 1'b0) n++;
        end
        chk(32'(n), 32'h0);
        rd(8'h10, 32'h7);
        event_in <= 1'b0;
        $display("test fault done");
        summarize();
    end
endmodule
